// ---- common/cs_pkg.sv ----
// Register map, field layout and carriers for the profile register bank.
// Assumes one byte-wide register per index; byte address = 4 * index.
package cs_pkg;

  // ---------------------------------------------------------------
  // Bus geometry and responses
  // ---------------------------------------------------------------
  localparam int         ADDR_W      = 14;
  localparam int         IDX_W       = 12;
  localparam int         IDX_LSB     = 2;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------
  // Register indices, first profile lock detectors
  // ---------------------------------------------------------------
  localparam logic [11:0] P1_PH_TH0   = 12'h65b;
  localparam logic [11:0] P1_PH_TH1   = 12'h65c;
  localparam logic [11:0] P1_PH_FILL  = 12'h65d;
  localparam logic [11:0] P1_PH_DRAIN = 12'h65e;
  localparam logic [11:0] P1_FR_TH0   = 12'h65f;
  localparam logic [11:0] P1_FR_TH1   = 12'h660;
  localparam logic [11:0] P1_FR_TH2   = 12'h661;
  localparam logic [11:0] P1_FR_FILL  = 12'h662;
  localparam logic [11:0] P1_FR_DRAIN = 12'h663;
  localparam logic [11:0] GAP_FIRST   = 12'h664;
  localparam logic [11:0] GAP_LAST    = 12'h67f;

  // ---------------------------------------------------------------
  // Register indices, second profile
  // ---------------------------------------------------------------
  localparam logic [11:0] P2_PRIO   = 12'h680;
  localparam logic [11:0] P2_PER0   = 12'h681;
  localparam logic [11:0] P2_PER1   = 12'h682;
  localparam logic [11:0] P2_PER2   = 12'h683;
  localparam logic [11:0] P2_PER3   = 12'h684;
  localparam logic [11:0] P2_PER4   = 12'h685;
  localparam logic [11:0] P2_PER5   = 12'h686;
  localparam logic [11:0] P2_PER6   = 12'h687;
  localparam logic [11:0] P2_ITOL0  = 12'h688;
  localparam logic [11:0] P2_ITOL1  = 12'h689;
  localparam logic [11:0] P2_ITOL2  = 12'h68a;
  localparam logic [11:0] P2_OTOL0  = 12'h68b;
  localparam logic [11:0] P2_OTOL1  = 12'h68c;
  localparam logic [11:0] P2_OTOL2  = 12'h68d;
  localparam logic [11:0] P2_VAL0   = 12'h68e;
  localparam logic [11:0] P2_VAL1   = 12'h68f;
  localparam logic [11:0] P2_RED0   = 12'h690;
  localparam logic [11:0] P2_RED1   = 12'h691;
  localparam logic [11:0] P2_ALIN0  = 12'h692;
  localparam logic [11:0] P2_ALIN1  = 12'h693;
  localparam logic [11:0] P2_AEXP   = 12'h694;
  localparam logic [11:0] P2_BLIN0  = 12'h695;
  localparam logic [11:0] P2_BLIN1  = 12'h696;
  localparam logic [11:0] P2_BEXP   = 12'h697;
  localparam logic [11:0] P2_GLIN0  = 12'h698;
  localparam logic [11:0] P2_GLIN1  = 12'h699;
  localparam logic [11:0] P2_GEXP   = 12'h69a;
  localparam logic [11:0] P2_DLIN0  = 12'h69b;
  localparam logic [11:0] P2_DLIN1  = 12'h69c;
  localparam logic [11:0] P2_DEXP   = 12'h69d;
  localparam logic [11:0] P2_RDIV0  = 12'h69e;
  localparam logic [11:0] P2_RDIV1  = 12'h69f;
  localparam logic [11:0] P2_RDIV2  = 12'h6a0;
  localparam logic [11:0] P2_RDIV3  = 12'h6a1;
  localparam logic [11:0] BANK_FIRST = P1_PH_TH0;
  localparam logic [11:0] BANK_LAST  = P2_RDIV3;
  localparam logic [11:0] APPLY_IDX  = 12'h800;
  localparam logic [11:0] STATUS_IDX = 12'h801;

  // ---------------------------------------------------------------
  // Field positions, masks and reset values
  // ---------------------------------------------------------------
  localparam int         SCALE_BIT    = 7;
  localparam int         PROMO_LSB    = 3;
  localparam int         SEL_LSB      = 0;
  localparam int         APPLY_BIT    = 0;
  localparam int         ST_PEND_BIT  = 0;
  localparam int         ST_ORDER_BIT = 1;
  localparam logic [7:0] MASK_PRIO    = 8'hbf;
  localparam logic [7:0] MASK_2       = 8'h03;
  localparam logic [7:0] MASK_4       = 8'h0f;
  localparam logic [7:0] MASK_6       = 8'h3f;
  localparam logic [7:0] MASK_7       = 8'h7f;
  localparam logic [7:0] MASK_FULL    = 8'hff;
  localparam logic [7:0] MASK_NONE    = 8'h00;
  localparam logic [7:0] BYTE_RST     = 8'h00;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic             en;
    logic [IDX_W-1:0] idx;
    logic [7:0]       data;
  } reg_wr_t;

  typedef struct packed {
    logic        p1_ph_scale_ns;
    logic [15:0] p1_ph_thresh;
    logic [7:0]  p1_ph_fill;
    logic [7:0]  p1_ph_drain;
    logic [23:0] p1_fr_thresh;
    logic [7:0]  p1_fr_fill;
    logic [7:0]  p1_fr_drain;
    logic        p2_ph_scale_ns;
    logic [2:0]  p2_promo_prio;
    logic [2:0]  p2_sel_prio;
    logic [49:0] p2_ref_period;
    logic [19:0] p2_inner_tol;
    logic [19:0] p2_outer_tol;
    logic [15:0] p2_valid_ms;
    logic [15:0] p2_redet_ms;
    logic [15:0] alpha_lin;
    logic [5:0]  alpha_exp1;
    logic [2:0]  alpha_exp2;
    logic [3:0]  alpha_exp3;
    logic [16:0] beta_lin;
    logic [4:0]  beta_exp;
    logic [16:0] gamma_lin;
    logic [4:0]  gamma_exp;
    logic [14:0] delta_lin;
    logic [4:0]  delta_exp;
    logic [29:0] p2_rdiv;
    logic [30:0] p2_rdiv_ratio;
  } cfg_t;

  // Writable bits of each bank byte
  function automatic logic [7:0] wmask(input logic [11:0] idx);
    case (idx)
      P2_PRIO:            return MASK_PRIO;
      P2_PER6:            return MASK_2;
      P2_ITOL2, P2_OTOL2: return MASK_4;
      P2_BEXP:            return MASK_7;
      P2_GEXP, P2_RDIV3:  return MASK_6;
      default: begin
        if (idx >= GAP_FIRST && idx <= GAP_LAST) return MASK_NONE;
        return MASK_FULL;
      end
    endcase
  endfunction

  // Index answered with OKAY
  function automatic logic mapped(input logic [11:0] idx);
    return (idx >= BANK_FIRST && idx <= BANK_LAST) ||
           idx == APPLY_IDX || idx == STATUS_IDX;
  endfunction

endpackage

// ---- core/profile_byte_cell.sv ----
// One staged byte and one applied byte of the profile bank.
// Assumes the parent decodes the index and issues the apply strobe.
`timescale 1ns/1ps
`default_nettype none
module profile_byte_cell #(
  parameter logic [7:0] MASK = 8'hff
) (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       reset_n,
  // Write and apply strobes
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_byte,
  input  wire logic       apply,
  // Stored bytes
  output logic      [7:0] stg,
  output logic      [7:0] act
);

  logic [7:0] stg_ff;
  logic [7:0] act_ff;
  logic [7:0] nxt_stg;
  logic [7:0] nxt_act;

  // Staged byte takes writes, applied byte takes the staged one
  always_comb begin
    nxt_stg = stg_ff;
    nxt_act = act_ff;
    if (wr_en) begin
      nxt_stg = wr_byte & MASK;
    end
    if (apply) begin
      nxt_act = stg_ff;
    end
  end

  // State registers
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      stg_ff <= cs_pkg::BYTE_RST;
      act_ff <= cs_pkg::BYTE_RST;
    end else begin
      stg_ff <= nxt_stg;
      act_ff <= nxt_act;
    end
  end

  assign stg = stg_ff;
  assign act = act_ff;

endmodule
`default_nettype wire

// ---- core/clock_sync_profile_regs.sv ----
// Profile register bank of a digital PLL clock synchronizer: first
// profile lock detectors and the whole second profile, on AXI4-Lite.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Priority bit 7 picks ps or ns
// - First profile threshold unit from p1_phase_scale_ns
// - 16-bit phase threshold, then fill, drain
// - 24-bit frequency threshold, low byte first
// - Frequency fill and drain follow threshold
// - Promoted priority only while reference active
// - 3-bit selection priority ranks the reference
// - 50-bit reference period over seven bytes
// - Two 20-bit tolerances, low nibble third
// - 16-bit validation timer in milliseconds
// - 16-bit redetect timer in milliseconds
// - Coefficient is fraction times power two
// - Alpha: linear, three exponents, split field
// - Beta: 17-bit linear, exponent bits 6:2
// - Gamma: linear top bit 0, exponent 5:1
// - Delta: 15-bit linear, exponent split two bytes
// - Input divide ratio is value plus one
module clock_sync_profile_regs #(
  parameter int ADDR_W = cs_pkg::ADDR_W
) (
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              reset_n,
  // AXI4-Lite write address and data
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Device state
  input  wire logic              p1_phase_scale_ns,
  input  wire logic              p2_ref_active,
  // Applied configuration
  output cs_pkg::cfg_t           cfg,
  output logic [2:0]             p2_eff_prio
);

  localparam int IW = cs_pkg::IDX_W;

  // -------------------------------------------------------------
  // Bus slave state
  // -------------------------------------------------------------
  logic            aw_held_ff;
  logic            w_held_ff;
  logic [IW-1:0]   aw_idx_ff;
  logic [7:0]      wbyte_ff;
  logic            wlane_ff;
  logic            awready_ff;
  logic            wready_ff;
  logic            bvalid_ff;
  logic [1:0]      bresp_ff;
  logic            arready_ff;
  logic            rvalid_ff;
  logic [31:0]     rdata_ff;
  logic [1:0]      rresp_ff;
  logic            nxt_aw_held;
  logic            nxt_w_held;
  logic [IW-1:0]   nxt_aw_idx;
  logic [7:0]      nxt_wbyte;
  logic            nxt_wlane;
  logic            nxt_awready;
  logic            nxt_wready;
  logic            nxt_bvalid;
  logic [1:0]      nxt_bresp;
  logic            nxt_arready;
  logic            nxt_rvalid;
  logic [31:0]     nxt_rdata;
  logic [1:0]      nxt_rresp;
  cs_pkg::reg_wr_t reg_wr;
  logic [IW-1:0]   rd_idx;
  logic [7:0]      rd_byte;

  // -------------------------------------------------------------
  // Bank and applied state
  // -------------------------------------------------------------
  logic [7:0]   stg_w [cs_pkg::BANK_FIRST:cs_pkg::BANK_LAST];
  logic [7:0]   act_w [cs_pkg::BANK_FIRST:cs_pkg::BANK_LAST];
  logic         bank_wr;
  logic         apply;
  logic         pending_ff;
  logic         nxt_pending;
  logic         order_err;
  cs_pkg::cfg_t cfg_ff;
  cs_pkg::cfg_t nxt_cfg;
  logic [2:0]   eff_prio_ff;
  logic [2:0]   nxt_eff_prio;

  // -------------------------------------------------------------
  // AXI4-Lite slave
  // -------------------------------------------------------------

  // Read index straight from the offered address
  assign rd_idx = IW'(s_axi_araddr >> cs_pkg::IDX_LSB);

  // Address and data taken in either order, write once both held
  always_comb begin
    nxt_aw_held = aw_held_ff;
    nxt_w_held  = w_held_ff;
    nxt_aw_idx  = aw_idx_ff;
    nxt_wbyte   = wbyte_ff;
    nxt_wlane   = wlane_ff;
    nxt_bvalid  = bvalid_ff;
    nxt_bresp   = bresp_ff;
    nxt_rvalid  = rvalid_ff;
    nxt_rdata   = rdata_ff;
    nxt_rresp   = rresp_ff;
    reg_wr      = '0;
    if (s_axi_awvalid && awready_ff) begin
      nxt_aw_held = 1'b1;
      nxt_aw_idx  = IW'(s_axi_awaddr >> cs_pkg::IDX_LSB);
    end
    if (s_axi_wvalid && wready_ff) begin
      nxt_w_held = 1'b1;
      nxt_wbyte  = s_axi_wdata[7:0];
      nxt_wlane  = s_axi_wstrb[0];
    end
    if (aw_held_ff && w_held_ff) begin
      // Unmapped index is dropped and answered SLVERR
      reg_wr.en   = wlane_ff && cs_pkg::mapped(aw_idx_ff);
      reg_wr.idx  = aw_idx_ff;
      reg_wr.data = wbyte_ff;
      nxt_aw_held = 1'b0;
      nxt_w_held  = 1'b0;
      nxt_bvalid  = 1'b1;
      nxt_bresp   = cs_pkg::mapped(aw_idx_ff) ?
                    cs_pkg::RESP_OKAY : cs_pkg::RESP_SLVERR;
    end else if (bvalid_ff && s_axi_bready) begin
      nxt_bvalid = 1'b0;
    end
    if (s_axi_arvalid && arready_ff) begin
      nxt_rvalid = 1'b1;
      nxt_rdata  = {24'h000000, rd_byte};
      nxt_rresp  = cs_pkg::mapped(rd_idx) ?
                   cs_pkg::RESP_OKAY : cs_pkg::RESP_SLVERR;
    end else if (rvalid_ff && s_axi_rready) begin
      nxt_rvalid = 1'b0;
    end
    nxt_awready = !nxt_aw_held && !nxt_bvalid;
    nxt_wready  = !nxt_w_held && !nxt_bvalid;
    nxt_arready = !nxt_rvalid;
  end

  // Slave registers
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      aw_held_ff <= 1'b0;
      w_held_ff  <= 1'b0;
      aw_idx_ff  <= '0;
      wbyte_ff   <= cs_pkg::BYTE_RST;
      wlane_ff   <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff  <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= cs_pkg::RESP_OKAY;
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 32'h00000000;
      rresp_ff   <= cs_pkg::RESP_OKAY;
    end else begin
      aw_held_ff <= nxt_aw_held;
      w_held_ff  <= nxt_w_held;
      aw_idx_ff  <= nxt_aw_idx;
      wbyte_ff   <= nxt_wbyte;
      wlane_ff   <= nxt_wlane;
      awready_ff <= nxt_awready;
      wready_ff  <= nxt_wready;
      bvalid_ff  <= nxt_bvalid;
      bresp_ff   <= nxt_bresp;
      arready_ff <= nxt_arready;
      rvalid_ff  <= nxt_rvalid;
      rdata_ff   <= nxt_rdata;
      rresp_ff   <= nxt_rresp;
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready  = wready_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;

  // -------------------------------------------------------------
  // Register bank
  // -------------------------------------------------------------

  // Write strobes for the bank and the apply command
  assign bank_wr = reg_wr.en && reg_wr.idx >= cs_pkg::BANK_FIRST &&
                   reg_wr.idx <= cs_pkg::BANK_LAST;
  assign apply   = reg_wr.en && reg_wr.idx == cs_pkg::APPLY_IDX &&
                   reg_wr.data[cs_pkg::APPLY_BIT];

  // One staged and applied byte per index, gap bytes masked off
  for (genvar i = int'(cs_pkg::BANK_FIRST);
       i <= int'(cs_pkg::BANK_LAST); i++) begin : g_cell
    localparam logic [IW-1:0] IDX = IW'(i);
    profile_byte_cell #(
      .MASK (cs_pkg::wmask(IDX))
    ) u_cell (
      .core_clk (core_clk),
      .reset_n  (reset_n),
      .wr_en    (bank_wr && reg_wr.idx == IDX),
      .wr_byte  (reg_wr.data),
      .apply    (apply),
      .stg      (stg_w[i]),
      .act      (act_w[i])
    );
  end

  // Pending flag, a new write wins over a same-cycle apply
  always_comb begin
    nxt_pending = pending_ff;
    if (apply) begin
      nxt_pending = 1'b0;
    end
    if (bank_wr) begin
      nxt_pending = 1'b1;
    end
  end

  // Applied promoted priority above selection priority
  assign order_err = cfg_ff.p2_promo_prio > cfg_ff.p2_sel_prio;

  // Read data: staged bytes, status, zero elsewhere
  always_comb begin
    rd_byte = 8'h00;
    if (rd_idx >= cs_pkg::BANK_FIRST && rd_idx <= cs_pkg::BANK_LAST) begin
      rd_byte = stg_w[rd_idx];
    end else if (rd_idx == cs_pkg::STATUS_IDX) begin
      rd_byte[cs_pkg::ST_PEND_BIT]  = pending_ff;
      rd_byte[cs_pkg::ST_ORDER_BIT] = order_err;
    end
  end

  // -------------------------------------------------------------
  // Field assembly from the applied bytes
  // -------------------------------------------------------------
  always_comb begin
    nxt_cfg = '0;
    // First profile lock detectors
    nxt_cfg.p1_ph_scale_ns = p1_phase_scale_ns;
    nxt_cfg.p1_ph_thresh = {act_w[cs_pkg::P1_PH_TH1],
                            act_w[cs_pkg::P1_PH_TH0]};
    nxt_cfg.p1_ph_fill   = act_w[cs_pkg::P1_PH_FILL];
    nxt_cfg.p1_ph_drain  = act_w[cs_pkg::P1_PH_DRAIN];
    nxt_cfg.p1_fr_thresh = {act_w[cs_pkg::P1_FR_TH2],
                            act_w[cs_pkg::P1_FR_TH1],
                            act_w[cs_pkg::P1_FR_TH0]};
    nxt_cfg.p1_fr_fill   = act_w[cs_pkg::P1_FR_FILL];
    nxt_cfg.p1_fr_drain  = act_w[cs_pkg::P1_FR_DRAIN];
    // Second profile priorities and scale
    nxt_cfg.p2_ph_scale_ns =
      act_w[cs_pkg::P2_PRIO][cs_pkg::SCALE_BIT];
    nxt_cfg.p2_promo_prio =
      act_w[cs_pkg::P2_PRIO][cs_pkg::PROMO_LSB +: 3];
    nxt_cfg.p2_sel_prio =
      act_w[cs_pkg::P2_PRIO][cs_pkg::SEL_LSB +: 3];
    // Reference period, tolerances, timers
    nxt_cfg.p2_ref_period = {act_w[cs_pkg::P2_PER6][1:0],
                             act_w[cs_pkg::P2_PER5],
                             act_w[cs_pkg::P2_PER4],
                             act_w[cs_pkg::P2_PER3],
                             act_w[cs_pkg::P2_PER2],
                             act_w[cs_pkg::P2_PER1],
                             act_w[cs_pkg::P2_PER0]};
    nxt_cfg.p2_inner_tol = {act_w[cs_pkg::P2_ITOL2][3:0],
                            act_w[cs_pkg::P2_ITOL1],
                            act_w[cs_pkg::P2_ITOL0]};
    nxt_cfg.p2_outer_tol = {act_w[cs_pkg::P2_OTOL2][3:0],
                            act_w[cs_pkg::P2_OTOL1],
                            act_w[cs_pkg::P2_OTOL0]};
    nxt_cfg.p2_valid_ms = {act_w[cs_pkg::P2_VAL1],
                           act_w[cs_pkg::P2_VAL0]};
    nxt_cfg.p2_redet_ms = {act_w[cs_pkg::P2_RED1],
                           act_w[cs_pkg::P2_RED0]};
    // Loop filter: linear parts are fractions below one, scaled
    // by two to the exponent downstream
    nxt_cfg.alpha_lin  = {act_w[cs_pkg::P2_ALIN1],
                          act_w[cs_pkg::P2_ALIN0]};
    nxt_cfg.alpha_exp1 = act_w[cs_pkg::P2_AEXP][5:0];
    nxt_cfg.alpha_exp2 = {act_w[cs_pkg::P2_BLIN0][0],
                          act_w[cs_pkg::P2_AEXP][7:6]};
    nxt_cfg.alpha_exp3 = act_w[cs_pkg::P2_DEXP][7:4];
    nxt_cfg.beta_lin   = {act_w[cs_pkg::P2_BEXP][1:0],
                          act_w[cs_pkg::P2_BLIN1],
                          act_w[cs_pkg::P2_BLIN0][7:1]};
    nxt_cfg.beta_exp   = act_w[cs_pkg::P2_BEXP][6:2];
    nxt_cfg.gamma_lin  = {act_w[cs_pkg::P2_GEXP][0],
                          act_w[cs_pkg::P2_GLIN1],
                          act_w[cs_pkg::P2_GLIN0]};
    nxt_cfg.gamma_exp  = act_w[cs_pkg::P2_GEXP][5:1];
    nxt_cfg.delta_lin  = {act_w[cs_pkg::P2_DLIN1][6:0],
                          act_w[cs_pkg::P2_DLIN0]};
    nxt_cfg.delta_exp  = {act_w[cs_pkg::P2_DEXP][3:0],
                          act_w[cs_pkg::P2_DLIN1][7]};
    // Input divider and its effective ratio
    nxt_cfg.p2_rdiv = {act_w[cs_pkg::P2_RDIV3][5:0],
                       act_w[cs_pkg::P2_RDIV2],
                       act_w[cs_pkg::P2_RDIV1],
                       act_w[cs_pkg::P2_RDIV0]};
    nxt_cfg.p2_rdiv_ratio = {1'b0, nxt_cfg.p2_rdiv} + 31'h1;
  end

  // Promoted priority only while this reference is active
  always_comb begin
    nxt_eff_prio = cfg_ff.p2_sel_prio;
    if (p2_ref_active) begin
      nxt_eff_prio = cfg_ff.p2_promo_prio;
    end
  end

  // Applied outputs and status registers
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      pending_ff  <= 1'b0;
      cfg_ff      <= '0;
      eff_prio_ff <= 3'h0;
    end else begin
      pending_ff  <= nxt_pending;
      cfg_ff      <= nxt_cfg;
      eff_prio_ff <= nxt_eff_prio;
    end
  end

  assign cfg         = cfg_ff;
  assign p2_eff_prio = eff_prio_ff;

endmodule
`default_nettype wire

// ---- sim/clock_sync_profile_regs_monitor.sv ----
// Checker for the profile register bank, bound to its top ports.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module clock_sync_profile_regs_monitor #(
  parameter int ADDR_W = cs_pkg::ADDR_W
) (
  // Clock and reset
  input wire logic              core_clk,
  input wire logic              reset_n,
  // Bus side
  input wire logic              s_axi_bvalid,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic [1:0]        s_axi_rresp,
  input wire logic              s_axi_rvalid,
  // Device side
  input wire logic              p2_ref_active,
  input wire cs_pkg::cfg_t      cfg,
  input wire logic [2:0]        p2_eff_prio
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // Index of the read address
  logic [11:0] ridx;
  assign ridx = s_axi_araddr[13:2];
  sequence ar_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence no_resp;
    !s_axi_bvalid ##1 !s_axi_bvalid;
  endsequence
  rd_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  rd_unmapped_a: assert property (ar_taken and ridx > cs_pkg::BANK_LAST
    && ridx < cs_pkg::APPLY_IDX |=> s_axi_rresp == cs_pkg::RESP_SLVERR)
    else $error("unmapped read not refused");
  rd_bank_a: assert property (ar_taken and ridx >= cs_pkg::BANK_FIRST
    && ridx <= cs_pkg::BANK_LAST |=> s_axi_rresp == cs_pkg::RESP_OKAY)
    else $error("bank read refused");
  eff_promo_a: assert property ($past(reset_n) && $past(p2_ref_active)
    |-> p2_eff_prio == $past(cfg.p2_promo_prio))
    else $error("promoted priority not used");
  eff_select_a: assert property ($past(reset_n) && !$past(p2_ref_active)
    |-> p2_eff_prio == $past(cfg.p2_sel_prio))
    else $error("selection priority not used");
  ratio_plus_a: assert property ($changed(cfg.p2_rdiv) |->
    cfg.p2_rdiv_ratio == {1'h0, cfg.p2_rdiv} + 31'h1)
    else $error("divide ratio wrong");
  cfg_apply_a: assert property ($changed(cfg.p2_ref_period) |-> $past(s_axi_bvalid))
    else $error("period changed without apply");
  cfg_stable_a: assert property (no_resp |=> $stable(cfg.p2_outer_tol))
    else $error("tolerance changed without apply");
endmodule
bind clock_sync_profile_regs clock_sync_profile_regs_monitor #(.ADDR_W(ADDR_W))
  i_clock_sync_profile_regs_monitor (.core_clk, .reset_n, .s_axi_bvalid,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .p2_ref_active, .cfg, .p2_eff_prio);
`default_nettype wire

// ---- sim/clock_sync_profile_regs_test.sv ----
// Self-checking bench for the profile register bank over AXI4-Lite.
// Assumes the package and the design are compiled first.
`timescale 1ns/1ps
`default_nettype none
module clock_sync_profile_regs_test;
  localparam logic [1:0] okay = cs_pkg::RESP_OKAY;
  logic         core_clk, reset_n, p1_phase_scale_ns, p2_ref_active;
  logic [13:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0]  s_axi_wdata, s_axi_rdata;
  logic [3:0]   s_axi_wstrb;
  logic [1:0]   s_axi_bresp, s_axi_rresp;
  logic         s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic         s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic         s_axi_rvalid, s_axi_rready;
  logic [2:0]   p2_eff_prio;
  cs_pkg::cfg_t cfg;
  int           bad_count = 0, check_count = 0, cycles = 0;
  clock_sync_profile_regs i_clock_sync_profile_regs (.core_clk, .reset_n,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .p1_phase_scale_ns, .p2_ref_active, .cfg,
    .p2_eff_prio);
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  // One write, address and data offered together
  task automatic wr(input logic [11:0] i, input logic [7:0] d, input logic [1:0] r);
    @(posedge core_clk);
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {i, 2'h0, 24'h0, d, 4'h1};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge core_clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      #1;
    end while (s_axi_awvalid || s_axi_wvalid);
    do @(posedge core_clk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk("bresp", r, s_axi_bresp);
  endtask
  // One read, compared with the expected byte and response
  task automatic rd(input logic [11:0] i, input logic [7:0] d, input logic [1:0] r);
    @(posedge core_clk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {i, 2'h0, 2'h3};
    do @(posedge core_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge core_clk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk("rdata", {24'h0, d}, s_axi_rdata);
    chk("rresp", r, s_axi_rresp);
  endtask
  // Every byte gets its own index low byte, gap included
  task automatic fill_bank();
    for (int k = cs_pkg::BANK_FIRST; k <= cs_pkg::BANK_LAST; k++)
      wr(k[11:0], k[7:0], okay);
    rd(cs_pkg::P2_PRIO, 8'h80, okay);
    rd(cs_pkg::P2_PER6, 8'h03, okay);
    rd(cs_pkg::P2_ITOL2, 8'h0a, okay);
    rd(cs_pkg::P2_BEXP, 8'h17, okay);
    rd(cs_pkg::P2_GEXP, 8'h1a, okay);
    rd(cs_pkg::P2_RDIV3, 8'h21, okay);
    rd(12'h670, 8'h00, okay);
    wr(12'h700, 8'hff, cs_pkg::RESP_SLVERR);
    rd(12'h700, 8'h00, cs_pkg::RESP_SLVERR);
    chk("staged", 64'h0, cfg.p2_ref_period);
  endtask
  // Apply and compare every assembled field except the promoted and selection priorities
  task automatic apply_check();
    wr(cs_pkg::APPLY_IDX, 8'h01, okay);
    repeat (2) @(posedge core_clk);
    #1;
    chk("p1 ph", {1'h1, 16'h5c5b, 8'h5d, 8'h5e},
      {cfg.p1_ph_scale_ns, cfg.p1_ph_thresh, cfg.p1_ph_fill,
       cfg.p1_ph_drain});
    chk("p1 fr", {24'h61605f, 8'h62, 8'h63},
      {cfg.p1_fr_thresh, cfg.p1_fr_fill, cfg.p1_fr_drain});
    chk("scale", 1'h1, cfg.p2_ph_scale_ns);
    chk("period", 50'h3_8685_8483_8281, cfg.p2_ref_period);
    chk("tol", 40'ha8988_d8c8b,
      {cfg.p2_inner_tol, cfg.p2_outer_tol});
    chk("timers", 32'h8f8e_9190,
      {cfg.p2_valid_ms, cfg.p2_redet_ms});
    chk("alpha", {16'h9392, 6'h14, 3'h6, 4'h9},
      {cfg.alpha_lin, cfg.alpha_exp1, cfg.alpha_exp2, cfg.alpha_exp3});
    chk("beta", {2'h3, 8'h96, 7'h4a, 5'h05},
      {cfg.beta_lin, cfg.beta_exp});
    chk("gamma", {1'h0, 16'h9998, 5'h0d},
      {cfg.gamma_lin, cfg.gamma_exp});
    chk("delta", {7'h1c, 8'h9b, 5'h1b},
      {cfg.delta_lin, cfg.delta_exp});
    chk("rdiv", {30'h21a09f9e, 31'h21a09f9f},
      {cfg.p2_rdiv, cfg.p2_rdiv_ratio});
  endtask
  // Promoted against selection priority as the reference goes active
  task automatic prio_swap();
    wr(cs_pkg::P2_PRIO, 8'h55, okay);
    rd(cs_pkg::STATUS_IDX, 8'h01, okay);
    wr(cs_pkg::APPLY_IDX, 8'h01, okay);
    rd(cs_pkg::STATUS_IDX, 8'h00, okay);
    p2_ref_active <= 1'b1;
    p1_phase_scale_ns <= 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
    chk("promoted", 5'h02,
      {cfg.p1_ph_scale_ns, cfg.p2_ph_scale_ns, p2_eff_prio});
    @(posedge core_clk);
    p2_ref_active <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    chk("selected", 3'h5, p2_eff_prio);
    rd(cs_pkg::P2_PRIO, 8'h15, okay);
  endtask
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  // Hang guard
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 4000) begin
      bad_count++;
      close_out();
    end
  end
  initial begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
    {s_axi_rready, p2_ref_active, reset_n, p1_phase_scale_ns} = 4'h1;
    repeat (20) @(posedge core_clk);
    reset_n <= 1'b1;
    fill_bank();
    apply_check();
    prio_swap();
    close_out();
  end
endmodule
`default_nettype wire
